// ---- include/aq_regs.svh ----
// Constants for the reference trigger and acquisition buffering block
`ifndef AQ_REGS_SVH
`define AQ_REGS_SVH
`define AQ_DATA_W      24
`define AQ_RAW_W       26
`define AQ_CHAN_W      6
`define AQ_CNT_W       16
`define AQ_FIFO_DEPTH  16384
`define AQ_CODE_MAX    24'hffffff
`define AQ_CODE_MIN    24'h000000
`define AQ_RAW_MID     26'h0800000
`define AQ_RAW_TOP     26'h0ffffff
`endif

// ---- include/aq_pkg.sv ----
// Types shared by the acquisition control block
package aq_pkg;
   typedef enum logic [1:0] {
      AQ_SRC_SW,
      AQ_SRC_EXT,
      AQ_SRC_THR,
      AQ_SRC_NONE
   } aq_src_t;
   typedef enum logic [1:0] {
      AQ_IND_OFF,
      AQ_IND_AMBER,
      AQ_IND_GREEN
   } aq_ind_t;
   typedef enum logic [2:0] {
      AQ_ST_IDLE,
      AQ_ST_WAIT_START,
      AQ_ST_PRE,
      AQ_ST_POST,
      AQ_ST_STOP
   } aq_state_t;
endpackage

// ---- include/aq_fifo_if.sv ----
// Valid/ready carrier between the acquisition control and its sample FIFO
`timescale 1ns/100ps
`default_nettype none
`include "aq_regs.svh"
interface aq_fifo_if;
   logic                   wvalid;
   logic                   wready;
   logic [`AQ_DATA_W-1:0]  wdata;
   logic                   rvalid;
   logic                   rready;
   logic [`AQ_DATA_W-1:0]  rdata;
   modport ctl  (output wvalid, output wdata, input wready, input rvalid, input rdata, output rready);
   modport fifo (input wvalid, input wdata, output wready, output rvalid, output rdata, input rready);
endinterface
`default_nettype wire

// ---- design/aq_fifo.sv ----
// Sample FIFO with registered read data and valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module aq_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16384
) (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Fill and drain ports
   aq_fifo_if.fifo    fp
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    rptr_r;
   logic [AW:0]      cnt_r;
   logic [WIDTH-1:0] rdata_r;
   logic             rvalid_r;
   logic             push;
   logic             pop;

   // Output register is not counted; a word leaves cnt_r when it is loaded
   assign fp.wready = (cnt_r != (AW+1)'(DEPTH));
   assign push      = fp.wvalid && fp.wready;
   assign pop       = (cnt_r != '0) && (!rvalid_r || fp.rready);
   assign fp.rvalid = rvalid_r;
   assign fp.rdata  = rdata_r;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr_r] <= fp.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + AW'(1);
         end
         if (pop) begin
            rptr_r <= rptr_r + AW'(1);
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else if (pop) begin
         rdata_r  <= mem[rptr_r];
         rvalid_r <= 1'b1;
      end else if (fp.rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- design/aq_ref_trig_ctl.sv ----
// Acquisition control: start and reference triggers, coding, FIFO and host buffers
`timescale 1ns/100ps
`default_nettype none
`include "aq_regs.svh"
// Summary of operation
// - Reference trigger from external input fires on its configured edge.
// - Positive polarity means rising edge, negative means falling edge.
// - Threshold reference fires when the selected channel crosses the level.
// - Positive threshold fires low-to-high, negative fires high-to-low.
// - Threshold channel may be any channel present in the scan.
// - Indicator amber while armed (green while awaiting a software start), green once triggered, off when idle.
// - Results are offset binary, zeros negative and ones positive full scale.
// - Over-range saturates to all ones, under-range to all zeros.
// - A buffer-done pulse is raised when each host buffer fills.
// - Buffers fill back to back; acquisition stops when none remain.
// - Samples pass through a 16 kSample input FIFO.
// - Overrun is raised when a sample meets a full FIFO.
// - After overrun both capture and host transfer cease.
// - Post capture starts after the trigger scan and counts programmed scans.
// - Capture begins only after the start trigger; scans are simultaneous.
module aq_ref_trig_ctl (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Acquisition configuration
   input  wire logic                   acq_arm,
   input  wire logic                   acq_abort,
   input  wire aq_pkg::aq_src_t        start_src,
   input  wire logic                   start_pos,
   input  wire aq_pkg::aq_src_t        ref_src,
   input  wire logic                   ref_pos,
   input  wire logic [`AQ_CHAN_W-1:0]  thr_chan,
   input  wire logic [`AQ_DATA_W-1:0]  thr_level,
   input  wire logic [`AQ_CNT_W-1:0]   post_scans,
   input  wire logic [`AQ_CNT_W-1:0]   buf_words,
   // External trigger pin
   input  wire logic                   ext_trigger_input,
   // Converter samples
   input  wire logic                   smp_valid,
   input  wire logic [`AQ_CHAN_W-1:0]  smp_chan,
   input  wire logic                   smp_last,
   input  wire logic [`AQ_RAW_W-1:0]   smp_raw,
   // Host buffer stream
   input  wire logic                   buf_post,
   output logic [`AQ_DATA_W-1:0]       host_data,
   output logic                        host_valid,
   input  wire logic                   host_ready,
   output logic                        host_last,
   // Status
   output logic                        buf_done,
   output logic                        overrun,
   output logic                        acq_busy,
   output aq_pkg::aq_ind_t             trigger_state_indicator
);
   aq_fifo_if fifo_bus ();

   aq_pkg::aq_state_t        st_r;
   aq_pkg::aq_state_t        st_nxt;
   logic                     ext_prev_r;
   logic                     thr_prev_r;
   logic                     thr_seen_r;
   logic                     ref_hit_r;
   logic                     ovr_r;
   logic [`AQ_CNT_W-1:0]     post_cnt_r;
   logic [`AQ_CNT_W-1:0]     bufs_r;
   logic [`AQ_CNT_W-1:0]     word_cnt_r;
   logic [`AQ_DATA_W-1:0]    host_data_r;
   logic                     host_valid_r;
   logic                     host_last_r;
   logic                     buf_done_r;
   logic                     acq_busy_r;
   aq_pkg::aq_ind_t          ind_r;
   logic [`AQ_DATA_W-1:0]    code;
   logic                     thr_smp;
   logic                     thr_above;
   logic                     ext_rise;
   logic                     ext_fall;
   logic                     start_ev;
   logic                     ref_ev;
   logic                     capturing;
   logic                     scan_end;
   logic                     out_load;
   logic                     word_take;
   logic                     buf_fill;

   // Offset binary with clamping of out-of-range converter results
   function automatic logic [`AQ_DATA_W-1:0] sat_code(input logic [`AQ_RAW_W-1:0] raw);
      logic [`AQ_RAW_W-1:0] ofs;
      ofs = raw + `AQ_RAW_MID;
      if (raw[`AQ_RAW_W-1] && ofs[`AQ_RAW_W-1]) begin
         sat_code = `AQ_CODE_MIN;
      end else if (!raw[`AQ_RAW_W-1] && (ofs > `AQ_RAW_TOP)) begin
         sat_code = `AQ_CODE_MAX;
      end else begin
         sat_code = ofs[`AQ_DATA_W-1:0];
      end
   endfunction

   // Common trigger qualification for start and reference sources
   function automatic logic trig_hit(input aq_pkg::aq_src_t src,
                                     input logic pos,
                                     input logic rise,
                                     input logic fall,
                                     input logic tprev,
                                     input logic tnow,
                                     input logic tvalid);
      trig_hit = 1'b0;
      unique case (src)
         aq_pkg::AQ_SRC_SW:   trig_hit = 1'b1;
         aq_pkg::AQ_SRC_EXT:  trig_hit = pos ? rise : fall;
         aq_pkg::AQ_SRC_THR:  trig_hit = tvalid && (pos ? (!tprev && tnow) : (tprev && !tnow));
         aq_pkg::AQ_SRC_NONE: trig_hit = 1'b0;
      endcase
   endfunction

   assign code      = sat_code(smp_raw);
   assign thr_smp   = smp_valid && (smp_chan == thr_chan);
   assign thr_above = code > thr_level;
   assign ext_rise  = ext_trigger_input && !ext_prev_r;
   assign ext_fall  = !ext_trigger_input && ext_prev_r;
   assign start_ev  = trig_hit(start_src, start_pos, ext_rise, ext_fall,
                               thr_prev_r, thr_above, thr_smp && thr_seen_r);
   assign ref_ev    = trig_hit(ref_src, ref_pos, ext_rise, ext_fall,
                               thr_prev_r, thr_above, thr_smp && thr_seen_r);
   assign capturing = (st_r == aq_pkg::AQ_ST_PRE) || (st_r == aq_pkg::AQ_ST_POST);
   assign scan_end  = capturing && smp_valid && smp_last;

   // Edge and threshold history
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_r <= 1'b0;
         thr_prev_r <= 1'b0;
         thr_seen_r <= 1'b0;
      end else begin
         ext_prev_r <= ext_trigger_input;
         if (acq_arm) begin
            thr_seen_r <= 1'b0;
         end else if (thr_smp) begin
            thr_prev_r <= thr_above;
            thr_seen_r <= 1'b1;
         end
      end
   end

   // Sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         aq_pkg::AQ_ST_IDLE: begin
            if (acq_arm) begin
               st_nxt = aq_pkg::AQ_ST_WAIT_START;
            end
         end
         aq_pkg::AQ_ST_WAIT_START: begin
            if (start_ev) begin
               st_nxt = (ref_src == aq_pkg::AQ_SRC_NONE) ? aq_pkg::AQ_ST_POST : aq_pkg::AQ_ST_PRE;
            end
         end
         aq_pkg::AQ_ST_PRE: begin
            if ((ref_hit_r || ref_ev) && scan_end) begin
               st_nxt = (post_scans == '0) ? aq_pkg::AQ_ST_STOP : aq_pkg::AQ_ST_POST;
            end
         end
         aq_pkg::AQ_ST_POST: begin
            if (scan_end && (ref_src != aq_pkg::AQ_SRC_NONE) && (post_cnt_r + `AQ_CNT_W'(1) == post_scans)) begin
               st_nxt = aq_pkg::AQ_ST_STOP;
            end
         end
         aq_pkg::AQ_ST_STOP: begin
            if (acq_arm) begin
               st_nxt = aq_pkg::AQ_ST_WAIT_START;
            end
         end
      endcase
      if ((ovr_r && !acq_arm) || acq_abort || (st_r != aq_pkg::AQ_ST_IDLE && st_r != aq_pkg::AQ_ST_STOP && bufs_r == '0)) begin
         st_nxt = aq_pkg::AQ_ST_STOP;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= aq_pkg::AQ_ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Reference trigger latched once; later conditions ignored until rearm
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_hit_r <= 1'b0;
      end else if (acq_arm) begin
         ref_hit_r <= 1'b0;
      end else if (st_r == aq_pkg::AQ_ST_PRE && ref_ev) begin
         ref_hit_r <= 1'b1;
      end
   end

   // Post-trigger scan counter; trigger scan is not counted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         post_cnt_r <= '0;
      end else if (st_r != aq_pkg::AQ_ST_POST) begin
         post_cnt_r <= '0;
      end else if (scan_end) begin
         post_cnt_r <= post_cnt_r + `AQ_CNT_W'(1);
      end
   end

   // Samples into the FIFO only while capturing
   assign fifo_bus.wvalid = capturing && smp_valid && !ovr_r;
   assign fifo_bus.wdata  = code;

   // Overrun is sticky; a new overrun in the rearm cycle wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_r <= 1'b0;
      end else if (fifo_bus.wvalid && !fifo_bus.wready) begin
         ovr_r <= 1'b1;
      end else if (acq_arm) begin
         ovr_r <= 1'b0;
      end
   end

   // Output stage: drain only into a posted buffer, never after overrun
   assign buf_fill        = host_valid_r && host_ready;
   assign out_load        = !host_valid_r || host_ready;
   // Last free buffer closing now leaves no room for another word
   assign word_take       = out_load && fifo_bus.rvalid && (bufs_r != '0) && !ovr_r &&
                            !(buf_fill && host_last_r && (bufs_r == `AQ_CNT_W'(1)));
   assign fifo_bus.rready = word_take;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_data_r  <= '0;
         host_valid_r <= 1'b0;
         host_last_r  <= 1'b0;
      end else if (ovr_r) begin
         host_valid_r <= 1'b0;
         host_last_r  <= 1'b0;
      end else if (out_load) begin
         host_data_r  <= fifo_bus.rdata;
         host_valid_r <= word_take;
         host_last_r  <= word_take && (word_cnt_r + `AQ_CNT_W'(1) == buf_words);
      end
   end

   // Word position within the current buffer, counted at the take
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_cnt_r <= '0;
      end else if (acq_arm) begin
         word_cnt_r <= '0;
      end else if (word_take) begin
         word_cnt_r <= (word_cnt_r + `AQ_CNT_W'(1) == buf_words) ? '0 : word_cnt_r + `AQ_CNT_W'(1);
      end
   end

   // Free buffers: posted by the host, retired as each one fills
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bufs_r <= '0;
      end else begin
         bufs_r <= bufs_r + `AQ_CNT_W'(buf_post) - `AQ_CNT_W'(buf_fill && host_last_r);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_done_r <= 1'b0;
      end else begin
         buf_done_r <= buf_fill && host_last_r;
      end
   end

   // Indicator and busy state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_r      <= aq_pkg::AQ_IND_OFF;
         acq_busy_r <= 1'b0;
      end else begin
         acq_busy_r <= (st_nxt != aq_pkg::AQ_ST_IDLE) && (st_nxt != aq_pkg::AQ_ST_STOP);
         unique case (st_nxt)
            aq_pkg::AQ_ST_WAIT_START:
               ind_r <= (start_src == aq_pkg::AQ_SRC_SW) ? aq_pkg::AQ_IND_GREEN : aq_pkg::AQ_IND_AMBER;
            aq_pkg::AQ_ST_PRE:
               ind_r <= aq_pkg::AQ_IND_AMBER;
            aq_pkg::AQ_ST_POST:
               ind_r <= aq_pkg::AQ_IND_GREEN;
            aq_pkg::AQ_ST_IDLE,
            aq_pkg::AQ_ST_STOP:
               ind_r <= aq_pkg::AQ_IND_OFF;
         endcase
      end
   end

   aq_fifo #(
      .WIDTH (`AQ_DATA_W),
      .DEPTH (`AQ_FIFO_DEPTH)
   ) u_fifo (
      .clk   (clk),
      .rst_n (rst_n),
      .fp    (fifo_bus.fifo)
   );

   assign host_data               = host_data_r;
   assign host_valid              = host_valid_r;
   assign host_last               = host_last_r;
   assign buf_done                = buf_done_r;
   assign overrun                 = ovr_r;
   assign acq_busy                = acq_busy_r;
   assign trigger_state_indicator = ind_r;
endmodule
`default_nettype wire

// ---- bench/aq_host_model.sv ----
// Host computer model: takes sample words, stalls or answers slowly, counts buffer events
`timescale 1ns/100ps
`default_nettype none
module aq_host_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Pacing from the bench
   input  wire logic        stall,
   input  wire logic        slow,
   // Word stream
   input  wire logic [23:0] host_data,
   input  wire logic        host_valid,
   input  wire logic        host_last,
   input  wire logic        buf_done,
   output logic             host_ready,
   // Observed traffic
   output logic [23:0]      rx_word,
   output logic [31:0]      rx_count,
   output logic [31:0]      last_count,
   output logic [31:0]      done_count
);
   logic tick_r;
   // Slow mode accepts on every other cycle
   assign host_ready = !stall && (!slow || tick_r);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_r     <= 1'b0;
         rx_word    <= 24'h000000;
         rx_count   <= 32'h0;
         last_count <= 32'h0;
         done_count <= 32'h0;
      end else begin
         tick_r     <= !tick_r;
         done_count <= done_count + {31'h0, buf_done};
         if (host_valid && host_ready) begin
            rx_word    <= host_data;
            rx_count   <= rx_count + 32'h1;
            last_count <= last_count + {31'h0, host_last};
         end
      end
   end
endmodule
`default_nettype wire

// ---- bench/aq_ref_trig_checker.sv ----
// Port assertions for the acquisition control block
`timescale 1ns/100ps
`default_nettype none
`include "aq_regs.svh"
module aq_ref_trig_checker (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // Watched ports
   input wire logic                  acq_arm,
   input wire aq_pkg::aq_src_t       start_src,
   input wire logic [`AQ_DATA_W-1:0] host_data,
   input wire logic                  host_valid,
   input wire logic                  host_ready,
   input wire logic                  host_last,
   input wire logic                  buf_done,
   input wire logic                  overrun,
   input wire logic                  acq_busy,
   input wire aq_pkg::aq_ind_t       trigger_state_indicator
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_last_taken;
      host_valid && host_ready && host_last;
   endsequence
   sequence s_word_stalled;
      host_valid && !host_ready ##1 !overrun;
   endsequence
   a_idle_ind_off: assert property (!acq_busy |-> trigger_state_indicator == aq_pkg::AQ_IND_OFF)
      else $error("indicator lit while idle");
   a_busy_ind_lit: assert property (acq_busy |-> trigger_state_indicator != aq_pkg::AQ_IND_OFF)
      else $error("indicator dark while busy");
   a_armed_amber: assert property ($rose(acq_busy) && start_src != aq_pkg::AQ_SRC_SW
      |-> trigger_state_indicator == aq_pkg::AQ_IND_AMBER) else $error("armed without amber");
   a_done_follows: assert property (s_last_taken |=> buf_done)
      else $error("buffer done missing");
   a_done_cause: assert property (buf_done |-> $past(host_last) && $past(host_valid) && $past(host_ready))
      else $error("buffer done without last word");
   a_word_held: assert property (s_word_stalled |-> host_valid && $stable(host_data))
      else $error("stalled word dropped or changed");
   a_ovr_sticky: assert property (overrun && !acq_arm |=> overrun)
      else $error("overrun cleared");
   a_ovr_quiet: assert property ($rose(overrun) |-> ##2 (!host_valid) [*4])
      else $error("transfer after overrun");
   a_ovr_stops: assert property ($rose(overrun) |-> ##[0:2] !acq_busy)
      else $error("capture after overrun");
   a_arm_clears: assert property (acq_arm && !acq_busy |=> !overrun)
      else $error("arm left overrun set");
endmodule
bind aq_ref_trig_ctl aq_ref_trig_checker u_aq_ref_trig_checker (
   .clk, .rst_n, .acq_arm, .start_src, .host_data, .host_valid, .host_ready, .host_last,
   .buf_done, .overrun, .acq_busy, .trigger_state_indicator);
`default_nettype wire

// ---- bench/aq_ref_trig_ctl_tb.sv ----
// Self-checking bench for the acquisition control block
`timescale 1ns/100ps
`default_nettype none
`include "aq_regs.svh"
module aq_ref_trig_ctl_tb;
   typedef struct packed {
      logic [25:0] raw;
      logic [23:0] code;
   } aq_row_t;
   localparam aq_row_t ROWS [6] = '{'{26'h3800000, 24'h000000}, '{26'h07fffff, 24'hffffff},
      '{26'h0000000, 24'h800000}, '{26'h0000001, 24'h800001}, '{26'h1000000, 24'hffffff},
      '{26'h37fffff, 24'h000000}};
   localparam logic [25:0] NEG = 26'h3ffff9c;
   localparam logic [25:0] POS = 26'h0000064;
   logic            clk = 1'b0, rst_n = 1'b0, acq_arm = 1'b0, acq_abort = 1'b0, buf_post = 1'b0;
   aq_pkg::aq_src_t start_src = aq_pkg::AQ_SRC_SW, ref_src = aq_pkg::AQ_SRC_NONE;
   logic            start_pos = 1'b1, ref_pos = 1'b1, ext_trigger_input = 1'b0;
   // Level inside the span; same channel and level for both triggers
   logic [5:0]      thr_chan = 6'h05;
   logic [23:0]     thr_level = 24'h800000;
   logic [15:0]     post_scans = 16'h0000, buf_words = 16'h0003;
   logic            smp_valid = 1'b0, smp_last = 1'b0, stall = 1'b0, slow = 1'b0, pos;
   logic [5:0]      smp_chan = 6'h00;
   logic [25:0]     smp_raw = 26'h0000000, lo, hi;
   logic [23:0]     host_data, rx_word;
   logic            host_valid, host_ready, host_last, buf_done, overrun, acq_busy;
   aq_pkg::aq_ind_t ind;
   logic [31:0]     rx_count, last_count, done_count, base;
   int              bad_count = 0, checked = 0;
   aq_ref_trig_ctl u_aq_ref_trig_ctl (
      .clk, .rst_n, .acq_arm, .acq_abort, .start_src, .start_pos, .ref_src, .ref_pos, .thr_chan,
      .thr_level, .post_scans, .buf_words, .ext_trigger_input, .smp_valid, .smp_chan, .smp_last,
      .smp_raw, .buf_post, .host_data, .host_valid, .host_ready, .host_last, .buf_done, .overrun,
      .acq_busy, .trigger_state_indicator(ind));
   aq_host_model u_aq_host_model (
      .clk, .rst_n, .stall, .slow, .host_data, .host_valid, .host_last, .buf_done, .host_ready,
      .rx_word, .rx_count, .last_count, .done_count);
   always #4 clk = !clk;
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic idle(input int n);
      @(negedge clk);
      {smp_valid, acq_arm, buf_post, acq_abort} = 4'h0;
      repeat (n - 1) @(negedge clk);
   endtask
   task automatic smp(input logic [5:0] ch, input logic last, input logic [25:0] raw);
      @(negedge clk);
      {smp_valid, smp_chan, smp_last, smp_raw} = {1'b1, ch, last, raw};
   endtask
   task automatic scan(input logic [25:0] a, input logic [25:0] b);
      smp(6'h02, 1'b0, a);
      smp(6'h05, 1'b1, b);
      idle(2);
   endtask
   task automatic wait_words(input logic [31:0] n);
      for (int i = 0; i < 300 && rx_count < n; i++) @(posedge clk);
      idle(3);
   endtask
   task automatic setup(input aq_pkg::aq_src_t ss, input aq_pkg::aq_src_t rs, input logic [15:0] ps,
                        input logic [15:0] bw, input int nbuf);
      @(negedge clk);
      start_src = ss;
      ref_src = rs;
      {post_scans, buf_words} = {ps, bw};
      repeat (nbuf) begin
         @(negedge clk);
         buf_post = 1'b1;
         @(negedge clk);
         buf_post = 1'b0;
      end
      @(negedge clk);
      acq_arm = 1'b1;
      idle(2);
      base = rx_count;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      bad_count++;
      $display("BAD watchdog expected end seen hang");
      finish_test();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("reset outputs", {host_valid, buf_done, overrun, acq_busy, ind}, 32'h0);
      slow = 1'b1;
      setup(aq_pkg::AQ_SRC_SW, aq_pkg::AQ_SRC_NONE, 16'h0000, 16'h0003, 2);
      for (int i = 0; i < 6; i++) begin
         smp(6'h00, 1'b1, ROWS[i].raw);
         idle(1);
         wait_words(base + i + 1);
         chk("word", rx_word, ROWS[i].code);
      end
      idle(3);
      chk("buffers done", done_count, 32'h2);
      chk("last words", last_count, 32'h2);
      chk("busy after buffers", acq_busy, 1'b0);
      // Awkward cases: wrong edge and wrong channel come before the real trigger
      for (int k = 0; k < 4; k++) begin
         pos = k[0];
         {slow, ref_pos, ext_trigger_input} = {!pos, pos, pos};
         lo = pos ? NEG : POS;
         hi = pos ? POS : NEG;
         setup(aq_pkg::AQ_SRC_SW, k[1] ? aq_pkg::AQ_SRC_THR : aq_pkg::AQ_SRC_EXT, 16'h0001, 16'h0064, 1);
         scan(lo, lo);
         ext_trigger_input = !pos;
         scan(hi, lo);
         chk("armed", ind, aq_pkg::AQ_IND_AMBER);
         ext_trigger_input = pos;
         scan(hi, hi);
         chk("triggered", ind, aq_pkg::AQ_IND_GREEN);
         scan(lo, lo);
         chk("stopped", acq_busy, 1'b0);
         wait_words(base + 8);
         chk("scan words", rx_count - base, 32'h8);
      end
      ext_trigger_input = 1'b0;
      setup(aq_pkg::AQ_SRC_EXT, aq_pkg::AQ_SRC_NONE, 16'h0000, 16'h0064, 1);
      scan(POS, POS);
      chk("waiting start", {acq_busy, ind}, {1'b1, aq_pkg::AQ_IND_AMBER});
      ext_trigger_input = 1'b1;
      idle(3);
      chk("started", ind, aq_pkg::AQ_IND_GREEN);
      scan(POS, NEG);
      wait_words(base + 2);
      chk("words after start", rx_count - base, 32'h2);
      acq_abort = 1'b1;
      idle(3);
      chk("aborted", {acq_busy, ind}, 32'h0);
      stall = 1'b1;
      setup(aq_pkg::AQ_SRC_SW, aq_pkg::AQ_SRC_NONE, 16'h0000, 16'hffff, 1);
      repeat (`AQ_FIFO_DEPTH) smp(6'h00, 1'b1, POS);
      idle(3);
      chk("overrun at capacity", overrun, 1'b0);
      repeat (4) smp(6'h00, 1'b1, POS);
      idle(3);
      chk("overrun", {overrun, acq_busy}, 32'h2);
      stall = 1'b0;
      idle(20);
      chk("words after overrun", rx_count - base, 32'h0);
      acq_arm = 1'b1;
      idle(3);
      chk("overrun after arm", overrun, 1'b0);
      chk("busy after rearm", acq_busy, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
